/* File: hdl/sxa_map.svh */
// opcode patterns, instruction field positions and reset values of the subtract/xor datapath
`ifndef SXA_MAP_SVH
`define SXA_MAP_SVH

// ==========================================================
// opcode prefixes (compared against the top instruction bits)
`define SXA_OP_SUB_WB_WR 8'h1F
`define SXA_OP_XOR_WR 8'h3C
`define SXA_OP_XOR_WB_WR 8'h3D
`define SXA_OP_XOR_MEM 9'h070
`define SXA_OP_XOR_WB_MEM 9'h072

// ==========================================================
// instruction field positions
`define SXA_PFX8_MSB 15
`define SXA_PFX8_LSB 8
`define SXA_PFX9_MSB 15
`define SXA_PFX9_LSB 7
`define SXA_IMM_MSB 7
`define SXA_IMM_LSB 4
`define SXA_WR_MSB 3
`define SXA_WR_LSB 0
`define SXA_ADDR_MSB 6
`define SXA_ADDR_LSB 0

// ==========================================================
// reset values and timing
`define SXA_RESULT_RST 4'h0
`define SXA_CARRY_RST 1'b0
`define SXA_ZERO_RST 1'b0
`define SXA_OP_CYCLES 1

`endif

/* File: hdl/sxa_pkg.sv */
// types shared by the subtract/xor datapath
`default_nettype none
package sxa_pkg;
	typedef enum logic [2:0] {
		SXA_NONE,
		SXA_SUB_WB_WR,
		SXA_XOR_MEM,
		SXA_XOR_WR,
		SXA_XOR_WB_MEM,
		SXA_XOR_WB_WR
	} sxa_op_t;
endpackage
`default_nettype wire

/* File: hdl/sxa_result_unit.sv */
// combinational result and borrow for the subtract and xor forms
`timescale 1ns/1ps
`default_nettype none
module sxa_result_unit
	import sxa_pkg::*;
#(
	parameter int DATA_W = 4
) (
	input wire sxa_op_t op_in,
	input wire logic [DATA_W-1:0] wr_data_in,
	input wire logic [DATA_W-1:0] mem_data_in,
	input wire logic [DATA_W-1:0] main_result_register_in,
	input wire logic [DATA_W-1:0] imm_in,
	output logic [DATA_W-1:0] result_out,
	output logic borrow_out
);
	logic [DATA_W:0] diff;

	always_comb begin
		diff = {1'b0, wr_data_in} - {1'b0, imm_in};
		borrow_out = diff[DATA_W];
		result_out = main_result_register_in;
		unique case (op_in)
			SXA_SUB_WB_WR: result_out = diff[DATA_W-1:0];
			SXA_XOR_MEM, SXA_XOR_WB_MEM: result_out = mem_data_in ^ main_result_register_in;
			SXA_XOR_WR, SXA_XOR_WB_WR: result_out = wr_data_in ^ imm_in;
			SXA_NONE: result_out = main_result_register_in;
		endcase
	end
endmodule
`default_nettype wire

/* File: hdl/sxa_alu.sv */
// execution datapath for subtract-immediate-with-writeback and the four xor forms
// Functional notes
// - WR minus immediate to result, WR; carry, zero
// - memory xor result into result only; zero
// - WR xor immediate into result only; zero
// - memory xor result into memory and result
// - WR xor immediate into WR and result
// - decode memory xor-writeback prefix, 7-bit address
`timescale 1ns/1ps
`default_nettype none
`include "sxa_map.svh"
module sxa_alu
	import sxa_pkg::*;
#(
	parameter int DATA_W = 4,
	parameter int ADDR_W = 7,
	parameter int WR_W = 4
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic instr_valid_in,
	input wire logic [15:0] instr_in,
	input wire logic [DATA_W-1:0] mem_rdata_in,
	input wire logic [DATA_W-1:0] wr_rdata_in,
	output logic done_out,
	output logic [DATA_W-1:0] main_result_register_out,
	output logic carry_flag_out,
	output logic zero_flag_out,
	output logic mem_we_out,
	output logic [ADDR_W-1:0] mem_waddr_out,
	output logic [DATA_W-1:0] mem_wdata_out,
	output logic wr_we_out,
	output logic [WR_W-1:0] wr_waddr_out,
	output logic [DATA_W-1:0] wr_wdata_out
);
	// ==========================================================
	// elaboration checks
	// instruction fields are fixed at 4-bit data, 7-bit address, 4-bit WR index
	if (DATA_W != 4 || ADDR_W != 7 || WR_W != 4) begin : g_bad_params
		$error("sxa_alu: unsupported width parameters");
	end

	// ==========================================================
	// decode
	function automatic sxa_op_t decode_op(input logic valid, input logic [15:0] instr);
		sxa_op_t op;
		op = SXA_NONE;
		// 8-bit and 9-bit prefixes never overlap, so the test order is free
		if (valid) begin
			if (instr[`SXA_PFX8_MSB:`SXA_PFX8_LSB] == `SXA_OP_SUB_WB_WR) begin
				op = SXA_SUB_WB_WR;
			end else if (instr[`SXA_PFX8_MSB:`SXA_PFX8_LSB] == `SXA_OP_XOR_WR) begin
				op = SXA_XOR_WR;
			end else if (instr[`SXA_PFX8_MSB:`SXA_PFX8_LSB] == `SXA_OP_XOR_WB_WR) begin
				op = SXA_XOR_WB_WR;
			end else if (instr[`SXA_PFX9_MSB:`SXA_PFX9_LSB] == `SXA_OP_XOR_MEM) begin
				op = SXA_XOR_MEM;
			end else if (instr[`SXA_PFX9_MSB:`SXA_PFX9_LSB] == `SXA_OP_XOR_WB_MEM) begin
				op = SXA_XOR_WB_MEM;
			end
		end
		return op;
	endfunction

	sxa_op_t op;
	logic [DATA_W-1:0] imm;
	logic [WR_W-1:0] wr_idx;
	logic [ADDR_W-1:0] mem_addr;
	logic [DATA_W-1:0] result;
	logic borrow;

	assign op = decode_op(instr_valid_in, instr_in);
	assign imm = instr_in[`SXA_IMM_MSB:`SXA_IMM_LSB];
	assign wr_idx = instr_in[`SXA_WR_MSB:`SXA_WR_LSB];
	// address bits already sit msb first in the low seven bits
	assign mem_addr = instr_in[`SXA_ADDR_MSB:`SXA_ADDR_LSB];

	sxa_result_unit #(
		.DATA_W(DATA_W)
	) u_result (
		.op_in(op),
		.wr_data_in(wr_rdata_in),
		.mem_data_in(mem_rdata_in),
		.main_result_register_in(main_result_register_out),
		.imm_in(imm),
		.result_out(result),
		.borrow_out(borrow)
	);

	// ==========================================================
	// next state
	logic next_done;
	logic [DATA_W-1:0] next_main_result;
	logic next_carry;
	logic next_zero;
	logic next_mem_we;
	logic [ADDR_W-1:0] next_mem_waddr;
	logic [DATA_W-1:0] next_mem_wdata;
	logic next_wr_we;
	logic [WR_W-1:0] next_wr_waddr;
	logic [DATA_W-1:0] next_wr_wdata;

	always_comb begin
		next_done = 1'b0;
		next_main_result = main_result_register_out;
		next_carry = carry_flag_out;
		next_zero = zero_flag_out;
		next_mem_we = 1'b0;
		next_mem_waddr = mem_waddr_out;
		next_mem_wdata = mem_wdata_out;
		next_wr_we = 1'b0;
		next_wr_waddr = wr_waddr_out;
		next_wr_wdata = wr_wdata_out;
		if (op != SXA_NONE) begin
			// every form completes in the cycle after it is offered
			next_done = 1'b1;
			next_main_result = result;
			next_zero = (result == '0);
		end
		unique case (op)
			SXA_SUB_WB_WR: begin
				// carry reads as "no borrow"
				next_carry = ~borrow;
				next_wr_we = 1'b1;
				next_wr_waddr = wr_idx;
				next_wr_wdata = result;
			end
			SXA_XOR_WB_MEM: begin
				// no forwarding here: the far side must show this write to the next instruction
				next_mem_we = 1'b1;
				next_mem_waddr = mem_addr;
				next_mem_wdata = result;
			end
			SXA_XOR_WB_WR: begin
				next_wr_we = 1'b1;
				next_wr_waddr = wr_idx;
				next_wr_wdata = result;
			end
			// result-register-only forms and no instruction: no write strobe, carry left alone
			SXA_XOR_MEM, SXA_XOR_WR, SXA_NONE: begin
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			done_out <= 1'b0;
			main_result_register_out <= `SXA_RESULT_RST;
			carry_flag_out <= `SXA_CARRY_RST;
			zero_flag_out <= `SXA_ZERO_RST;
			mem_we_out <= 1'b0;
			mem_waddr_out <= '0;
			mem_wdata_out <= '0;
			wr_we_out <= 1'b0;
			wr_waddr_out <= '0;
			wr_wdata_out <= '0;
		end else begin
			done_out <= next_done;
			main_result_register_out <= next_main_result;
			carry_flag_out <= next_carry;
			zero_flag_out <= next_zero;
			mem_we_out <= next_mem_we;
			mem_waddr_out <= next_mem_waddr;
			mem_wdata_out <= next_mem_wdata;
			wr_we_out <= next_wr_we;
			wr_waddr_out <= next_wr_waddr;
			wr_wdata_out <= next_wr_wdata;
		end
	end

	// ==========================================================
	// assertions
	logic [DATA_W-1:0] ref_sub;
	logic [DATA_W-1:0] ref_xor_mem;
	logic [DATA_W-1:0] ref_xor_wr;
	logic ref_no_borrow;
	assign ref_sub = wr_rdata_in - imm;
	assign ref_no_borrow = (wr_rdata_in >= imm);
	assign ref_xor_mem = mem_rdata_in ^ main_result_register_out;
	assign ref_xor_wr = wr_rdata_in ^ imm;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	a_sub_wb_result: assert property (op == SXA_SUB_WB_WR |=> main_result_register_out == $past(ref_sub)
		&& carry_flag_out == $past(ref_no_borrow) && wr_we_out && wr_wdata_out == main_result_register_out
		&& wr_waddr_out == $past(wr_idx) && !mem_we_out)
		else $error("subtract writeback result wrong");
	a_xor_mem_result: assert property (op == SXA_XOR_MEM |=> main_result_register_out == $past(ref_xor_mem)
		&& !mem_we_out && !wr_we_out && carry_flag_out == $past(carry_flag_out))
		else $error("memory xor to result register wrong");
	a_xor_wr_result: assert property (op == SXA_XOR_WR |=> main_result_register_out == $past(ref_xor_wr)
		&& !mem_we_out && !wr_we_out && $stable(carry_flag_out))
		else $error("register xor to result register wrong");
	a_xor_wb_mem: assert property (op == SXA_XOR_WB_MEM |=> main_result_register_out == $past(ref_xor_mem)
		&& mem_we_out && mem_wdata_out == main_result_register_out && !wr_we_out && $stable(carry_flag_out))
		else $error("memory xor writeback wrong");
	a_xor_wb_wr: assert property (op == SXA_XOR_WB_WR |=> main_result_register_out == $past(ref_xor_wr)
		&& wr_we_out && wr_wdata_out == main_result_register_out && wr_waddr_out == $past(wr_idx)
		&& !mem_we_out)
		else $error("register xor writeback wrong");
	a_strobe_exclusive: assert property (!(mem_we_out && wr_we_out))
		else $error("both write strobes high together");
	a_mem_addr_decode: assert property (instr_valid_in && instr_in[15:7] == 9'h072
		|=> mem_we_out && mem_waddr_out == $past(instr_in[6:0]))
		else $error("memory xor writeback address wrong");
	a_zero_tracks: assert property (done_out |-> zero_flag_out == (main_result_register_out == '0))
		else $error("zero flag disagrees with result");
	// the edge that applies reset samples srst_in high, so the idle check must skip it
	a_idle_quiet: assert property (!srst_in && op == SXA_NONE |=> !done_out && !mem_we_out && !wr_we_out
		&& $stable(main_result_register_out) && $stable(zero_flag_out) && $stable(carry_flag_out))
		else $error("state changed without an instruction");

	// ==========================================================
	// coverage
	c_sub_borrow: cover property (op == SXA_SUB_WB_WR && !ref_no_borrow ##1 !carry_flag_out);
	c_sub_no_borrow: cover property (op == SXA_SUB_WB_WR && ref_no_borrow ##1 carry_flag_out);
	c_xor_wb_mem_zero: cover property (op == SXA_XOR_WB_MEM ##1 zero_flag_out);
	c_back_to_back: cover property (op == SXA_XOR_WR ##1 op == SXA_XOR_WB_WR ##1 wr_we_out);
	c_xor_mem: cover property (op == SXA_XOR_MEM ##1 done_out && !zero_flag_out);
endmodule
`default_nettype wire

/* File: tb/sxa_mem_model.sv */
// data memory and working registers on the far side of the datapath
`timescale 1ns/1ps
`default_nettype none
module sxa_mem_model (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic [15:0] instr_in,
	input wire logic mem_we_in,
	input wire logic [6:0] mem_waddr_in,
	input wire logic [3:0] mem_wdata_in,
	input wire logic wr_we_in,
	input wire logic [3:0] wr_waddr_in,
	input wire logic [3:0] wr_wdata_in,
	output logic [3:0] mem_rdata_out,
	output logic [3:0] wr_rdata_out
);
	logic [3:0] mem [128];
	logic [3:0] wr [16];
	// the datapath does not forward, so a write still in flight is passed through here
	always_comb begin
		mem_rdata_out = (mem_we_in && mem_waddr_in == instr_in[6:0]) ? mem_wdata_in : mem[instr_in[6:0]];
		wr_rdata_out = (wr_we_in && wr_waddr_in == instr_in[3:0]) ? wr_wdata_in : wr[instr_in[3:0]];
	end
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			for (int k = 0; k < 128; k++) begin
				mem[k] <= 4'(k) ^ 4'h5;
			end
			for (int k = 0; k < 16; k++) begin
				wr[k] <= ~4'(k);
			end
		end else begin
			if (mem_we_in) begin
				mem[mem_waddr_in] <= mem_wdata_in;
			end
			if (wr_we_in) begin
				wr[wr_waddr_in] <= wr_wdata_in;
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/sub_xor_writeback_alu_ops_tb_top.sv */
// self-checking bench for the subtract/xor datapath
`timescale 1ns/1ps
`default_nettype none
`include "sxa_map.svh"
module sub_xor_writeback_alu_ops_tb_top;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic instr_valid_in = 1'b0;
	logic [15:0] instr_in = 16'h0000;
	logic [3:0] mem_rdata, wr_rdata, res_reg, mem_wdata, wr_wdata, wr_waddr, p_res, e_res_reg;
	logic done, carry, zero, mem_we, wr_we, p_done, p_mwe, p_wwe, e_carry, e_zero;
	logic [6:0] mem_waddr, p_addr;
	logic [3:0] sh_mem [128];
	logic [3:0] sh_wr [16];
	int n_fail = 0;
	int check_count = 0;
	int cycles = 0;
	sxa_alu u_dut (.clk_in(clk_in), .srst_in(srst_in), .instr_valid_in(instr_valid_in), .instr_in(instr_in),
		.mem_rdata_in(mem_rdata), .wr_rdata_in(wr_rdata), .done_out(done), .main_result_register_out(res_reg),
		.carry_flag_out(carry), .zero_flag_out(zero), .mem_we_out(mem_we), .mem_waddr_out(mem_waddr),
		.mem_wdata_out(mem_wdata), .wr_we_out(wr_we), .wr_waddr_out(wr_waddr), .wr_wdata_out(wr_wdata));
	sxa_mem_model u_mem (.clk_in(clk_in), .srst_in(srst_in), .instr_in(instr_in), .mem_we_in(mem_we),
		.mem_waddr_in(mem_waddr), .mem_wdata_in(mem_wdata), .wr_we_in(wr_we), .wr_waddr_in(wr_waddr),
		.wr_wdata_in(wr_wdata), .mem_rdata_out(mem_rdata), .wr_rdata_out(wr_rdata));
	initial begin
		forever #2.5 clk_in = ~clk_in;
	end
	// ==========================================================
	// shared tasks
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic do_reset(input int n);
		@(posedge clk_in);
		srst_in <= 1'b1;
		instr_valid_in <= 1'b0;
		repeat (n) @(posedge clk_in);
		srst_in <= 1'b0;
		for (int k = 0; k < 128; k++) sh_mem[k] = 4'(k) ^ 4'h5;
		for (int k = 0; k < 16; k++) sh_wr[k] = ~4'(k);
		{e_res_reg, e_carry, e_zero, p_done, p_mwe, p_wwe} = '0;
	endtask
	// one cycle: offer an instruction, judge the one offered a cycle earlier
	task automatic step(input logic v, input logic [15:0] w);
		logic [3:0] r, res;
		@(posedge clk_in);
		instr_valid_in <= v;
		instr_in <= w;
		#1;
		chk("done", p_done, done);
		chk("result_reg", e_res_reg, res_reg);
		chk("carry", e_carry, carry);
		chk("zero", e_zero, zero);
		chk("mem_we", p_mwe, mem_we);
		chk("wr_we", p_wwe, wr_we);
		if (p_mwe) chk("mem_waddr", p_addr, mem_waddr);
		if (p_mwe) chk("mem_wdata", p_res, mem_wdata);
		if (p_wwe) chk("wr_waddr", p_addr[3:0], wr_waddr);
		if (p_wwe) chk("wr_wdata", p_res, wr_wdata);
		r = sh_wr[w[3:0]];
		{p_done, p_mwe, p_wwe} = {v, 2'b00};
		if (v && w[15:8] == `SXA_OP_SUB_WB_WR) begin
			res = r - w[7:4];
			e_carry = (r >= w[7:4]);
			p_wwe = 1'b1;
		end else if (v && (w[15:8] == `SXA_OP_XOR_WR || w[15:8] == `SXA_OP_XOR_WB_WR)) begin
			res = r ^ w[7:4];
			p_wwe = w[8];
		end else if (v && (w[15:7] == `SXA_OP_XOR_MEM || w[15:7] == `SXA_OP_XOR_WB_MEM)) begin
			res = sh_mem[w[6:0]] ^ e_res_reg;
			p_mwe = w[8];
		end else begin
			p_done = 1'b0;
		end
		if (p_done) begin
			{e_res_reg, e_zero, p_res, p_addr} = {res, res == 4'h0, res, w[6:0]};
			if (p_wwe) sh_wr[w[3:0]] = res;
			if (p_mwe) sh_mem[w[6:0]] = res;
		end
	endtask
	// ==========================================================
	// scenarios
	task automatic t_subtract();
		step(1'b1, 16'h1FA5);
		step(1'b1, 16'h1F15);
		step(1'b1, 16'h1F00);
		step(1'b0, 16'h1F00);
	endtask
	task automatic t_xor();
		step(1'b1, 16'h3C3A);
		step(1'b1, 16'h3CC3);
		step(1'b1, 16'h3D5B);
		step(1'b1, {9'h070, 7'h7F});
		step(1'b1, {9'h072, 7'h7F});
		step(1'b1, {9'h072, 7'h7F});
		step(1'b1, {9'h072, 7'h2A});
		step(1'b1, 16'h3DB5);
		step(1'b0, 16'h0000);
	endtask
	task automatic t_refused();
		step(1'b1, 16'h0000);
		step(1'b1, 16'h1E35);
		step(1'b1, 16'h3880);
		step(1'b0, 16'h1F12);
		step(1'b0, 16'h0000);
	endtask
	task automatic t_reset();
		step(1'b1, 16'h1F1F);
		do_reset(1);
		step(1'b0, 16'h0000);
	endtask
	// ==========================================================
	// run control
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 1000) begin
			n_fail++;
			report_and_stop();
		end
	end
	initial begin
		do_reset(3);
		t_subtract();
		t_xor();
		t_refused();
		t_reset();
		report_and_stop();
	end
endmodule
`default_nettype wire
